// >>> bench/tb_top.sv
// self-checking bench for the fault and status register bank
`timescale 1ns/1ps
module tb_top;
    import vrfs_pkg::*;
    logic       mclk = 0, rst = 1, reg_wr, reg_rd, alert, latch_off, hiccup, pcl_en, reflow;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, cur, volt, temp, lstrap, phl;
    logic [3:0] rstrap, ramp_code;
    logic [5:0] flt;
    logic [11:0] ramp_t;
    logic [7:0] q[$];
    logic       rd_p = 0;
    int         fail_count = 0, comparisons = 0, seed = 76;
    logic [7:0] fb [6] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h01};
    logic [7:0] sb [6] = '{8'h00, 8'h80, 8'h40, 8'h00, 8'h20, 8'h00};

    vrfs_host u_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd));
    vrfs_regs #(.PHASES(8)) u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .current_adc(cur), .voltage_adc(volt), .stage_temp_adc(temp),
        .ramp_strap_code(rstrap), .limit_strap_code(lstrap), .reference_low(reflow),
        .stage_temperature_monitor_trip(flt[1]), .thermal_shutdown_trip(flt[2]),
        .total_current_limit_trip(flt[3]), .input_undervoltage_trip(flt[0]),
        .overvoltage_protection_trip(flt[4]), .undervoltage_protection_trip(flt[5]),
        .per_phase_limit_trip(phl), .alert(alert), .latch_off(latch_off), .hiccup(hiccup),
        .phase_current_limiting_en(pcl_en), .ramp_code(ramp_code), .ramp_time_10us(ramp_t));

    always #2 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic miss(input string m);
        fail_count++;
        $display("MISMATCH %0t %s", $time, m);
    endtask
    task automatic chk(input logic [11:0] g, input logic [11:0] e, input string m);
        comparisons++;
        if (g !== e) begin
            miss($sformatf("%s got %h exp %h", m, g, e));
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        q.push_back(e);
        u_host.rd(a);
    endtask
    function automatic logic [11:0] rt(input logic [3:0] c, input logic lo);
        logic [11:0] t;
        t = (c <= 4'h5) ? 12'h00f * (c + 12'h001) : 12'h064 * (c - 12'h005);
        return lo ? 12'(t * 4 / 5) : t;
    endfunction

    // read results compared against the oldest note
    always @(posedge mclk) begin
        if (rd_p) begin
            comparisons++;
            if (q.size() == 0) begin
                miss("read without note");
            end else if (reg_rdata !== q[0]) begin
                miss($sformatf("read got %h exp %h", reg_rdata, q[0]));
            end
            if (q.size() != 0) begin
                void'(q.pop_front());
            end
        end
        rd_p = reg_rd;
    end

    initial begin
        #100000;
        miss("timeout");
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cur    = 8'h00;
        volt   = 8'($random(seed));
        temp   = 8'($random(seed));
        rstrap = 4'($random(seed));
        lstrap = 8'($random(seed));
        reflow = 1'($random(seed));
        flt    = 6'h00;
        phl    = 8'h00;
        cyc(6);
        rst = 0;
        cyc(3);
        chk(pcl_en, 1, "limiting enable");
        rc(OFS_WARN_LIMIT, 8'hff);
        rc(OFS_SUMMARY, 8'h00);
        rc(OFS_FAULT_MASK, 8'h00);
        rc(OFS_FAULT_STAT, 8'h00);
        rc(OFS_WARN_STAT, 8'h00);
        rc(8'h25, 8'h00);
        rc(OFS_LIMIT_STAT, lstrap);
        rc(OFS_RAMP_STAT, {4'h0, rstrap});
        for (int k = 0; k < GEN_N; k++) begin
            rc(GEN_OFS[k], GEN_RST[k]);
            u_host.wr(GEN_OFS[k], 8'h00);
        end
        chk(ramp_code, rstrap, "strap code");
        chk(ramp_t, rt(rstrap, reflow), "strap time");
        cur = 8'($random(seed));
        cyc(3);
        rc(OFS_IOUT, cur);
        rc(OFS_VOUT, volt);
        rc(OFS_TEMP, temp);
        $display("test reset and readback done");
        u_host.wr(OFS_FAULT_MASK, 8'h7b);
        for (int i = 0; i < 6; i++) begin
            u_host.wr(OFS_CLEAR, 8'h01);
            flt[i] = 1'b1;
            cyc(6);
            flt[i] = 1'b0;
            cyc(6);
            rc(OFS_FAULT_STAT, fb[i]);
            rc(OFS_SUMMARY, sb[i]);
            chk(latch_off, 0, "masked latch");
            chk(hiccup, 0, "masked hiccup");
        end
        $display("test masked faults done");
        u_host.wr(OFS_FAULT_MASK, 8'h04);
        cyc(2);
        chk(pcl_en, 0, "limiting off");
        phl = 8'h81;
        cyc(6);
        phl = 8'h00;
        cyc(6);
        rc(OFS_FAULT_STAT, 8'h01);
        rc(OFS_LIMIT_STAT, 8'h00);
        u_host.wr(OFS_FAULT_MASK, 8'h00);
        cyc(2);
        chk(pcl_en, 1, "limiting on");
        phl = 8'h81;
        cyc(6);
        phl = 8'h00;
        cyc(6);
        rc(OFS_FAULT_STAT, 8'h05);
        rc(OFS_LIMIT_STAT, 8'h81);
        u_host.wr(OFS_TEMP_RESP, 8'h01);
        flt[1] = 1'b1;
        cyc(6);
        chk(hiccup, 1, "hiccup");
        chk(latch_off, 0, "hiccup no latch");
        flt[1] = 1'b0;
        cyc(6);
        chk(hiccup, 0, "hiccup end");
        u_host.wr(OFS_CLEAR, 8'h01);
        flt[5] = 1'b1;
        cyc(6);
        flt[5] = 1'b0;
        chk(latch_off, 1, "unmasked latch");
        $display("test limiting and latch done");
        cur = 8'h10;
        u_host.wr(OFS_WARN_LIMIT, 8'h10);
        cyc(5);
        chk(alert, 0, "equal no alert");
        cur = 8'h11;
        for (int n = 0; n < 10 && alert !== 1'b1; n++) begin
            cyc(1);
        end
        chk(alert, 1, "alert");
        rc(OFS_SUMMARY, 8'h10);
        rc(OFS_WARN_STAT, 8'h01);
        cur = 8'h00;
        cyc(3);
        u_host.wr(OFS_CLEAR, 8'h01);
        cyc(3);
        chk(alert, 0, "alert cleared");
        rc(OFS_WARN_STAT, 8'h00);
        $display("test warning done");
        u_host.wr(OFS_RAMP_CFG, 8'h07);
        cyc(4);
        chk(ramp_code, rstrap, "unselected code");
        rc(OFS_RAMP_CFG, 8'h07);
        u_host.wr(OFS_SECOND_A, 8'h01);
        for (int c = 0; c < 16; c++) begin
            reflow = (c == 15) ? 1'b0 : 1'($random(seed));
            u_host.wr(OFS_RAMP_CFG, 8'(c));
            cyc(4);
            chk(ramp_code, 12'(c), "selected code");
            chk(ramp_t, rt(4'(c), reflow), "ramp time");
        end
        $display("test ramp done");
        // limits settled before locking
        u_host.wr(OFS_WARN_LIMIT, 8'h3c);
        u_host.wr(OFS_LOCK, 8'h01);
        u_host.wr(OFS_WARN_LIMIT, 8'h55);
        u_host.wr(OFS_LOCK, 8'h00);
        u_host.wr(OFS_FAULT_MASK, 8'h7f);
        rc(OFS_WARN_LIMIT, 8'h3c);
        rc(OFS_LOCK, 8'h01);
        rc(OFS_FAULT_MASK, 8'h00);
        cyc(3);
        rst = 1;
        cyc(2);
        rst = 0;
        cyc(3);
        rc(OFS_LOCK, 8'h00);
        rc(OFS_WARN_LIMIT, 8'hff);
        cyc(3);
        $display("test lock done");
        end_sim();
    end
endmodule

// >>> bench/vrfs_host.sv
// host model issuing single-byte register accesses
`timescale 1ns/1ps
module vrfs_host (
    input  wire logic       mclk,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end
    // one-cycle strobe, then one idle edge; released lines show scrambled values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
        @(posedge mclk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge mclk);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        @(posedge mclk);
        #1;
    endtask
endmodule

// >>> logic/vrfs_pkg.sv
// constants for the regulator fault and status register bank
package vrfs_pkg;
    localparam logic [7:0] OFS_WARN_LIMIT  = 8'h20;
    localparam logic [7:0] OFS_SUMMARY     = 8'h21;
    localparam logic [7:0] OFS_FAULT_MASK  = 8'h22;
    localparam logic [7:0] OFS_FAULT_STAT  = 8'h23;
    localparam logic [7:0] OFS_WARN_STAT   = 8'h24;
    localparam logic [7:0] OFS_IOUT        = 8'h26;
    localparam logic [7:0] OFS_LOCK        = 8'h2a;
    localparam logic [7:0] OFS_RAMP_STAT   = 8'h2b;
    localparam logic [7:0] OFS_RAMP_CFG    = 8'h2c;
    localparam logic [7:0] OFS_LIMIT_STAT  = 8'h2d;
    localparam logic [7:0] OFS_SHED3_STAT  = 8'h3f;
    localparam logic [7:0] OFS_SHED4_STAT  = 8'h41;
    localparam logic [7:0] OFS_SECOND_A    = 8'h46;
    localparam logic [7:0] OFS_SECOND_B    = 8'h47;
    localparam logic [7:0] OFS_VOUT        = 8'h48;
    localparam logic [7:0] OFS_TEMP        = 8'h49;
    localparam logic [7:0] OFS_TEMP_RESP   = 8'h4a;
    localparam logic [7:0] OFS_TSD_CFG     = 8'h4b;
    localparam logic [7:0] OFS_CLEAR       = 8'h52;

    // plain read/write configuration registers
    localparam int         GEN_N = 14;
    localparam logic [7:0] GEN_OFS [GEN_N] = '{8'h3e, 8'h40, 8'h44, 8'h45, 8'h4a, 8'h4b,
        8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h50, 8'h51, 8'h52, 8'h53};
    localparam logic [7:0] GEN_RST [GEN_N] = '{8'h00, 8'h00, 8'h08, 8'h14, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
    localparam logic [4:0] GEN_NONE = 5'h1f;

    localparam logic [7:0] RST_WARN_LIMIT = 8'hff;
    localparam logic [7:0] RST_ZERO       = 8'h00;

    // summary status bits
    localparam int SUM_TEMP = 7;
    localparam int SUM_TSD  = 6;
    localparam int SUM_OV   = 5;
    localparam int SUM_WARN = 4;
    // fault status and fault mask bits
    localparam int FLT_VIN_UV = 6;
    localparam int FLT_TEMP   = 5;
    localparam int FLT_TSD    = 4;
    localparam int FLT_TOTAL  = 3;
    localparam int FLT_PHASE  = 2;
    localparam int FLT_OV     = 1;
    localparam int FLT_UV     = 0;
    localparam int LOCK_BIT   = 0;
    localparam int RAMP_SEL   = 0;
    localparam int RESP_HICC  = 0;
    localparam int CLR_BIT    = 0;

    // ramp time table, units of 10 us at 1 V reference
    localparam logic [11:0] RAMP_FINE_STEP   = 12'h00f;
    localparam logic [11:0] RAMP_KNEE_TIME   = 12'h064;
    localparam logic [11:0] RAMP_COARSE_STEP = 12'h064;
    localparam logic [3:0]  RAMP_KNEE_CODE   = 4'h6;
    localparam logic [3:0]  RAMP_COARSE_BASE = 4'h5;
    localparam logic [11:0] RAMP_LOW_NUM     = 12'h004;
    localparam logic [11:0] RAMP_LOW_DEN     = 12'h005;
endpackage

// >>> logic/vrfs_regs.sv
// fault, status, lock and soft-start register bank of the regulator controller
`timescale 1ns/1ps
//
// Overview of operation
// - readback above warning limit (reset 0xff) sets warning flag and raises alert
// - summary: bit7 temp monitor, bit6 shutdown, bit5 overvoltage, bit4 current warning
// - mask bits 6,1,0 stop latch-off but fault still recorded
// - mask bits 5,4 stop latch-off and hiccup, bit 3 stops latch-off (no hiccup path), but fault still recorded
// - mask bit 2 switches off per-phase current limiting entirely
// - fault status bits 6..0 flag each fault; bit 7 reserved
// - warning status bit 0 set when current exceeds warning limit
// - current readback is 8-bit code, all ones means 2 V full scale
// - lock bit 0 makes lockable registers read-only until power cycle
// - strapped ramp code captured into ramp status at power-on
// - ramp config holds host-writable 4-bit code in bits 3:0
// - register ramp code used only when second-function select bit set
// - with reference_low clear, codes map 0.15 ms steps to 0.9 ms, then 1 ms steps to 10 ms
// - limit status takes strapped threshold at power-on, then per-phase limit bits
module vrfs_regs
    import vrfs_pkg::*;
#(
    parameter int PHASES = 8
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    input  wire logic [7:0]        current_adc,
    input  wire logic [7:0]        voltage_adc,
    input  wire logic [7:0]        stage_temp_adc,
    input  wire logic [3:0]        ramp_strap_code,
    input  wire logic [7:0]        limit_strap_code,
    input  wire logic              reference_low,
    input  wire logic              stage_temperature_monitor_trip,
    input  wire logic              thermal_shutdown_trip,
    input  wire logic              total_current_limit_trip,
    input  wire logic              input_undervoltage_trip,
    input  wire logic              overvoltage_protection_trip,
    input  wire logic              undervoltage_protection_trip,
    input  wire logic [PHASES-1:0] per_phase_limit_trip,
    output logic                   alert,
    output logic                   latch_off,
    output logic                   hiccup,
    output logic                   phase_current_limiting_en,
    output logic      [3:0]        ramp_code,
    output logic      [11:0]       ramp_time_10us
);
    import vrfs_pkg::*;

    localparam int EV_N = PHASES + 6;
    localparam int E_UV = 0;
    localparam int E_OV = 1;
    localparam int E_TM = 2;
    localparam int E_TS = 3;
    localparam int E_TC = 4;
    localparam int E_VI = 5;
    localparam int E_PH = 6;

    typedef struct packed {
        logic [EV_N-1:0]     s1;
        logic [EV_N-1:0]     s2;
        logic [EV_N-1:0]     s3;
        logic [EV_N-1:0]     evt;
        logic [7:0]          warn_limit;
        logic [7:0]          fmask;
        logic                lock;
        logic [3:0]          ramp_cfg;
        logic [7:0]          second_a;
        logic [7:0]          second_b;
        logic [GEN_N-1:0][7:0] gen;
        logic [7:0]          iout;
        logic [7:0]          summary;
        logic [7:0]          fault;
        logic                warn;
        logic [7:0]          plim;
        logic [3:0]          ramp_strap;
        logic                init;
        logic                latch;
        logic                hicc;
        logic                alert;
        logic                phase_en;
        logic [7:0]          rdata;
        logic [3:0]          ramp;
        logic [11:0]         ramp_time;
    } vrfs_state_s;

    vrfs_state_s st_q;
    vrfs_state_s st_d;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [4:0] gen_index(input logic [7:0] a);
        gen_index = GEN_NONE;
        for (int i = 0; i < GEN_N; i++) begin
            if (GEN_OFS[i] == a) begin
                gen_index = 5'(i);
            end
        end
    endfunction

    // ramp duration in 10 us units
    function automatic logic [11:0] ramp_time_of(input logic [3:0] c, input logic low);
        logic [11:0] t;
        t = 12'h000;
        if (c < RAMP_KNEE_CODE) begin
            t = 12'(({8'h00, c} + 12'h001) * RAMP_FINE_STEP);
        end else if (c == RAMP_KNEE_CODE) begin
            t = RAMP_KNEE_TIME;
        end else begin
            t = 12'({8'h00, c - RAMP_COARSE_BASE} * RAMP_COARSE_STEP);
        end
        if (low) begin
            t = 12'((t * RAMP_LOW_NUM) / RAMP_LOW_DEN);
        end
        ramp_time_of = t;
    endfunction

    logic [EV_N-1:0] trip_in;
    assign trip_in = {per_phase_limit_trip, input_undervoltage_trip, total_current_limit_trip,
                      thermal_shutdown_trip, stage_temperature_monitor_trip,
                      overvoltage_protection_trip, undervoltage_protection_trip};

    logic            wr_ok;
    logic [4:0]      gidx;
    logic            latch_evt;
    logic            hicc_evt;
    logic            clr;
    logic [7:0]      fault_set;
    logic [7:0]      plim_set;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_d  = st_q;
        gidx  = gen_index(reg_addr);
        wr_ok = reg_wr && !st_q.lock;
        clr   = reg_wr && (reg_addr == OFS_CLEAR) && reg_wdata[CLR_BIT];

        // three-stage pin synchroniser, change taken when stages two and three agree
        st_d.s1 = trip_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < EV_N; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.evt[i] = st_q.s3[i];
            end
        end

        st_d.iout = current_adc;

        // power-on capture of straps
        st_d.init = 1'b1;
        if (!st_q.init) begin
            st_d.ramp_strap = ramp_strap_code;
            st_d.plim       = limit_strap_code;
        end

        // fault recording, mask hides only the per-phase limit record (mask bit 2)
        fault_set = 8'h00;
        fault_set[FLT_VIN_UV] = st_q.evt[E_VI];
        fault_set[FLT_TEMP]   = st_q.evt[E_TM];
        fault_set[FLT_TSD]    = st_q.evt[E_TS];
        fault_set[FLT_TOTAL]  = st_q.evt[E_TC];
        fault_set[FLT_PHASE]  = |st_q.evt[EV_N-1:E_PH] && !st_q.fmask[FLT_PHASE];
        fault_set[FLT_OV]     = st_q.evt[E_OV];
        fault_set[FLT_UV]     = st_q.evt[E_UV];
        plim_set = st_q.fmask[FLT_PHASE] ? 8'h00 : 8'(st_q.evt[EV_N-1:E_PH]);

        // set wins over clear
        if (st_q.init) begin
            st_d.fault = ((clr ? 8'h00 : st_q.fault) | fault_set);
            st_d.plim  = ((clr ? 8'h00 : st_q.plim) | plim_set);
            st_d.summary = clr ? 8'h00 : st_q.summary;
            st_d.summary[SUM_TEMP] = st_d.summary[SUM_TEMP] | st_q.evt[E_TM];
            st_d.summary[SUM_TSD]  = st_d.summary[SUM_TSD] | st_q.evt[E_TS];
            st_d.summary[SUM_OV]   = st_d.summary[SUM_OV] | st_q.evt[E_OV];
            st_d.summary[SUM_WARN] = st_d.summary[SUM_WARN]
                                     | (st_q.iout > st_q.warn_limit);
            st_d.warn = (st_q.warn && !clr) | (st_q.iout > st_q.warn_limit);
        end
        st_d.alert = st_q.summary[SUM_WARN];

        // fault response: latch or hiccup unless masked
        latch_evt = (st_q.evt[E_VI] && !st_q.fmask[FLT_VIN_UV])
                  | (st_q.evt[E_OV] && !st_q.fmask[FLT_OV])
                  | (st_q.evt[E_UV] && !st_q.fmask[FLT_UV])
                  | (st_q.evt[E_TC] && !st_q.fmask[FLT_TOTAL])
                  | (st_q.evt[E_TM] && !st_q.fmask[FLT_TEMP] && !st_q.gen[4][RESP_HICC])
                  | (st_q.evt[E_TS] && !st_q.fmask[FLT_TSD] && !st_q.gen[5][RESP_HICC]);
        hicc_evt  = (st_q.evt[E_TM] && !st_q.fmask[FLT_TEMP] && st_q.gen[4][RESP_HICC])
                  | (st_q.evt[E_TS] && !st_q.fmask[FLT_TSD] && st_q.gen[5][RESP_HICC]);
        st_d.latch    = st_q.latch | latch_evt;
        st_d.hicc     = hicc_evt;
        st_d.phase_en = !st_q.fmask[FLT_PHASE];

        // soft-start source select
        st_d.ramp = st_q.second_a[RAMP_SEL] ? st_q.ramp_cfg : st_q.ramp_strap;
        st_d.ramp_time = ramp_time_of(st_q.ramp, reference_low);

        // host writes
        if (wr_ok) begin
            case (reg_addr)
                OFS_WARN_LIMIT: begin
                    st_d.warn_limit = reg_wdata;
                end
                OFS_FAULT_MASK: begin
                    st_d.fmask = reg_wdata;
                end
                OFS_LOCK: begin
                    st_d.lock = reg_wdata[LOCK_BIT];
                end
                OFS_RAMP_CFG: begin
                    st_d.ramp_cfg = reg_wdata[3:0];
                end
                OFS_SECOND_A: begin
                    st_d.second_a = reg_wdata;
                end
                OFS_SECOND_B: begin
                    st_d.second_b = reg_wdata;
                end
                default: begin
                    if (gidx != GEN_NONE) begin
                        st_d.gen[gidx] = reg_wdata;
                    end
                end
            endcase
        end
        if (reg_wr && st_q.lock && reg_addr == OFS_CLEAR) begin
            st_d.gen[12] = reg_wdata;
        end

        // host reads, answer one cycle later
        if (reg_rd) begin
            case (reg_addr)
                OFS_WARN_LIMIT: st_d.rdata = st_q.warn_limit;
                OFS_SUMMARY:    st_d.rdata = {st_q.summary[7:4], 4'h0};
                OFS_FAULT_MASK: st_d.rdata = st_q.fmask;
                OFS_FAULT_STAT: st_d.rdata = {1'b0, st_q.fault[6:0]};
                OFS_WARN_STAT:  st_d.rdata = {7'h00, st_q.warn};
                OFS_IOUT:       st_d.rdata = st_q.iout;
                OFS_LOCK:       st_d.rdata = {7'h00, st_q.lock};
                OFS_RAMP_STAT:  st_d.rdata = {4'h0, st_q.ramp_strap};
                OFS_RAMP_CFG:   st_d.rdata = {4'h0, st_q.ramp_cfg};
                OFS_LIMIT_STAT: st_d.rdata = st_q.plim;
                OFS_SECOND_A:   st_d.rdata = st_q.second_a;
                OFS_SECOND_B:   st_d.rdata = st_q.second_b;
                OFS_VOUT:       st_d.rdata = voltage_adc;
                OFS_TEMP:       st_d.rdata = stage_temp_adc;
                default: begin
                    st_d.rdata = (gidx != GEN_NONE) ? st_q.gen[gidx] : RST_ZERO;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q            <= '0;
            st_q.warn_limit <= RST_WARN_LIMIT;
            st_q.phase_en   <= 1'b1;
            for (int i = 0; i < GEN_N; i++) begin
                st_q.gen[i] <= GEN_RST[i];
            end
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata                 = st_q.rdata;
    assign alert                     = st_q.alert;
    assign latch_off                 = st_q.latch;
    assign hiccup                    = st_q.hicc;
    assign phase_current_limiting_en = st_q.phase_en;
    assign ramp_code                 = st_q.ramp;
    assign ramp_time_10us            = st_q.ramp_time;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_trip_held;
        trip_in[E_UV] [*4];
    endsequence

    sequence s_over_limit;
        st_q.init && (st_q.iout > st_q.warn_limit);
    endsequence

    a_warn_compare: assert property (s_over_limit |=> st_q.summary[SUM_WARN] && st_q.warn)
        else $error("current warning not flagged");
    a_alert_raise: assert property (s_over_limit |-> ##2 alert)
        else $error("alert not raised after warning");
    a_uv_record: assert property (s_trip_held ##1 st_q.init |=> st_q.fault[FLT_UV])
        else $error("undervoltage not recorded");
    a_mask_latch: assert property ($rose(latch_off) |-> $past(latch_evt))
        else $error("latch-off without unmasked fault");
    a_masked_uv: assert property (!latch_off && st_q.fmask[FLT_UV] && st_q.evt == EV_N'(1)
        |=> !latch_off)
        else $error("masked undervoltage latched off");
    a_phase_off: assert property (st_q.fmask[FLT_PHASE] |=> !phase_current_limiting_en)
        else $error("per-phase limiting not disabled");
    a_lock_hold: assert property (st_q.lock && reg_wr && reg_addr == OFS_WARN_LIMIT
        |=> $stable(st_q.warn_limit))
        else $error("locked register changed");
    a_lock_stays: assert property (st_q.lock |=> st_q.lock)
        else $error("lock released without power cycle");
    a_ramp_select: assert property (st_q.second_a[RAMP_SEL] ##1 st_q.second_a[RAMP_SEL]
        |-> ramp_code == $past(st_q.ramp_cfg))
        else $error("register ramp code not selected");
    a_strap_take: assert property ($rose(st_q.init) |-> st_q.ramp_strap == $past(ramp_strap_code))
        else $error("strap ramp code not captured");
    a_ramp_top: assert property (ramp_code == 4'hf && !reference_low ##1 !reference_low
        |-> ramp_time_10us == 12'h3e8)
        else $error("ramp time for top code wrong");
    a_limit_bit: assert property (st_q.init && st_q.evt[E_PH] && !st_q.fmask[FLT_PHASE]
        |=> st_q.plim[0])
        else $error("phase limit bit not set");
endmodule
